// [hdl/arf_cfg.svh]
// Constants for the upper-node asynchronous request acceptance filter
// ----------------------------------------------------------------------------
// What this block does
// [RULE1] Phys-request and async-receive packets are looked up by source node before acceptance.
// [RULE2] Source bit clear: no acknowledge sent and request not queued.
// [RULE3] Per-node bit comparison applies only to sources on our own bus.
// [RULE4] Foreign-bus packets stay unacknowledged unless bit 31 is one.
// [RULE5] Bit 31 set: every request from any foreign-bus node is accepted.
// [RULE6] Local node numbers below 32 go elsewhere; foreign-bus nodes of any number are judged here by bit 31.
// [RULE7] Bits 30..4 enable local nodes 62..36, bit n for node n plus 32.
// [RULE8] Ones written at set address set bits, at clear address clear them.
// [RULE9] Both addresses read back the filter; all bits reset to zero.
// [RULE10] Bits 3..0 enable local nodes 35..32 the same way.
// [RULE11] Local means bus field equals own bus or all-ones alias; index by node.
// ----------------------------------------------------------------------------
`ifndef ARF_CFG_SVH
`define ARF_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ARF_ADDR_W          12
`define ARF_SET_OFF         12'h100
`define ARF_CLR_OFF         12'h104
`define ARF_REJ_CNT_OFF     12'h180
`define ARF_ACC_CNT_OFF     12'h184
`define ARF_FILTER_RESET    32'h0000_0000
`define ARF_ZERO_WORD       32'h0000_0000

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define ARF_ALLBUS_BIT      31
`define ARF_NODE_BITS       31
`define ARF_UPPER_BASE      32
`define ARF_UPPER_MSB       5
`define ARF_LOCAL_ALIAS     10'h3ff
`define ARF_BCAST_NODE      6'h3f
`define ARF_CNT_W           16
`define ARF_CNT_ZERO        16'h0000
`define ARF_CNT_ONE         16'h0001
`define ARF_CNT_MAX         16'hffff

`endif

// [hdl/arf_pkg.sv]
// Types shared by the upper-node asynchronous request filter
package arf_pkg;

	// ------------------------------------------------------------------------
	// Receive context a packet is bound for
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CTX_PHYS_REQ,
		CTX_ASYNC_REQ_RX,
		CTX_OTHER
	} rx_ctx_e;

	// ------------------------------------------------------------------------
	// Source identifier and request descriptor
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [9:0] bus;
		logic [5:0] node;
	} src_id_s;

	typedef struct packed {
		src_id_s src;
		rx_ctx_e ctx;
	} rx_req_s;

	// ------------------------------------------------------------------------
	// Verdict handed back to the link layer
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic accept;
		logic send_ack;
		logic enqueue;
		logic to_lower_filter;
		logic nonlocal;
	} verdict_s;

	// ------------------------------------------------------------------------
	// Bus slave phase
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		APB_IDLE,
		APB_REPLY
	} apb_phase_e;

endpackage : arf_pkg

// [hdl/async_request_node_filter_high.sv]
// Upper-node asynchronous request acceptance filter with APB register access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`include "arf_cfg.svh"

module async_request_node_filter_high (
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`ARF_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Own bus identity
	input  wire logic [9:0]               own_bus_num,
	// Incoming request lookup
	input  wire logic                     rx_valid,
	input  wire arf_pkg::rx_req_s         rx_req,
	// Verdict
	output logic                          verdict_valid,
	output arf_pkg::verdict_s             verdict,
	// Filter contents for neighbouring logic
	output logic      [31:0]              filter_bits
);
	import arf_pkg::*;

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	apb_phase_e                 phase_r;
	logic [31:0]                filter_r;
	logic [31:0]                filter_nxt;
	logic [31:0]                prdata_r;
	logic                       pslverr_r;
	logic [31:0]                rd_word;
	logic                       rd_err;
	logic                       apb_access;
	logic                       commit;
	logic                       wr_set;
	logic                       wr_clr;
	logic                       wr_rej;
	logic                       wr_acc;
	logic                       src_local;
	logic                       ctx_filtered;
	logic                       node_upper;
	logic [`ARF_NODE_BITS-1:0]  node_sel;
	logic                       node_hit;
	verdict_s                   verdict_nxt;
	verdict_s                   verdict_r;
	logic                       verdict_valid_r;
	logic                       rejected_now;
	logic                       accepted_now;
	logic [`ARF_CNT_W-1:0]      rej_cnt_r;
	logic [`ARF_CNT_W-1:0]      acc_cnt_r;

	// ------------------------------------------------------------------------
	// APB phase tracking
	// ------------------------------------------------------------------------
	// One wait state so that read data leaves a flip-flop
	assign apb_access = psel & penable & (phase_r == APB_IDLE);
	assign commit     = psel & penable & (phase_r == APB_REPLY);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= APB_IDLE;
		end else begin
			case (phase_r)
				APB_IDLE: begin
					if (apb_access) begin
						phase_r <= APB_REPLY;
					end
				end
				APB_REPLY: begin
					phase_r <= APB_IDLE;
				end
				default: begin
					phase_r <= APB_IDLE;
				end
			endcase
		end
	end

	assign pready = (phase_r == APB_REPLY);

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	assign wr_set = commit & pwrite & (paddr == `ARF_SET_OFF);
	assign wr_clr = commit & pwrite & (paddr == `ARF_CLR_OFF);
	assign wr_rej = commit & pwrite & (paddr == `ARF_REJ_CNT_OFF);
	assign wr_acc = commit & pwrite & (paddr == `ARF_ACC_CNT_OFF);

	always_comb begin
		rd_word = `ARF_ZERO_WORD;
		rd_err  = 1'b0;
		case (paddr)
			`ARF_SET_OFF: begin
				rd_word = filter_r; // [RULE9]
			end
			`ARF_CLR_OFF: begin
				rd_word = filter_r; // [RULE9]
			end
			`ARF_REJ_CNT_OFF: begin
				rd_word = {{(32-`ARF_CNT_W){1'b0}}, rej_cnt_r};
			end
			`ARF_ACC_CNT_OFF: begin
				rd_word = {{(32-`ARF_CNT_W){1'b0}}, acc_cnt_r};
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Read data and error capture
	// ------------------------------------------------------------------------
	// Unmapped reads return zero; unmapped writes are dropped, both flag an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= `ARF_ZERO_WORD;
		end else if (apb_access) begin
			prdata_r <= pwrite ? `ARF_ZERO_WORD : rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else if (apb_access) begin
			pslverr_r <= rd_err;
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & pready;

	// ------------------------------------------------------------------------
	// Filter register
	// ------------------------------------------------------------------------
	// Zeros written leave bits untouched, so drivers need no read-modify-write
	always_comb begin
		filter_nxt = filter_r;
		if (wr_set) begin
			filter_nxt = filter_r | pwdata; // [RULE8]
		end else if (wr_clr) begin
			filter_nxt = filter_r & ~pwdata; // [RULE8]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_r <= `ARF_FILTER_RESET; // [RULE9]
		end else begin
			filter_r <= filter_nxt;
		end
	end

	assign filter_bits = filter_r;

	// ------------------------------------------------------------------------
	// Source classification
	// ------------------------------------------------------------------------
	// The alias covers packets sent before a bus number was assigned
	assign src_local = (rx_req.src.bus == own_bus_num)
		| (rx_req.src.bus == `ARF_LOCAL_ALIAS); // [RULE11]

	assign ctx_filtered = (rx_req.ctx == CTX_PHYS_REQ)
		| (rx_req.ctx == CTX_ASYNC_REQ_RX); // [RULE1]

	assign node_upper = rx_req.src.node[`ARF_UPPER_MSB]; // [RULE6]

	// ------------------------------------------------------------------------
	// Per-node bit select
	// ------------------------------------------------------------------------
	// Node 63 matches no entry: it has no enable bit, so a filtered request from local node 63 is never admitted
	genvar gi;
	generate
		for (gi = 0; gi < `ARF_NODE_BITS; gi = gi + 1) begin : g_node
			localparam logic [5:0] NODE_ID = 6'(`ARF_UPPER_BASE + gi);
			assign node_sel[gi] = (rx_req.src.node == NODE_ID); // [RULE7] [RULE10]
		end
	endgenerate

	assign node_hit = |(node_sel & filter_r[`ARF_NODE_BITS-1:0]); // [RULE3]

	// ------------------------------------------------------------------------
	// Verdict
	// ------------------------------------------------------------------------
	always_comb begin
		verdict_nxt = '0;
		verdict_nxt.nonlocal = ~src_local;
		if (!ctx_filtered) begin
			verdict_nxt.accept = 1'b1;
		end else if (!src_local) begin
			verdict_nxt.accept = filter_r[`ARF_ALLBUS_BIT]; // [RULE4] [RULE5]
		end else if (!node_upper) begin
			verdict_nxt.to_lower_filter = 1'b1; // [RULE6]
		end else begin
			verdict_nxt.accept = node_hit; // [RULE1] [RULE3]
		end
		verdict_nxt.send_ack = verdict_nxt.accept; // [RULE2]
		verdict_nxt.enqueue  = verdict_nxt.accept; // [RULE2]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			verdict_valid_r <= 1'b0;
		end else begin
			verdict_valid_r <= rx_valid;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			verdict_r <= '0;
		end else if (rx_valid) begin
			verdict_r <= verdict_nxt;
		end
	end

	assign verdict_valid = verdict_valid_r;
	assign verdict       = verdict_r;

	// ------------------------------------------------------------------------
	// Statistics counters
	// ------------------------------------------------------------------------
	// Counters saturate; a count landing with a clear write is kept
	assign rejected_now = rx_valid & ~verdict_nxt.accept & ~verdict_nxt.to_lower_filter;
	assign accepted_now = rx_valid & verdict_nxt.accept;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rej_cnt_r <= `ARF_CNT_ZERO;
		end else if (wr_rej) begin
			rej_cnt_r <= rejected_now ? `ARF_CNT_ONE : `ARF_CNT_ZERO;
		end else if (rejected_now && (rej_cnt_r != `ARF_CNT_MAX)) begin
			rej_cnt_r <= rej_cnt_r + `ARF_CNT_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_cnt_r <= `ARF_CNT_ZERO;
		end else if (wr_acc) begin
			acc_cnt_r <= accepted_now ? `ARF_CNT_ONE : `ARF_CNT_ZERO;
		end else if (accepted_now && (acc_cnt_r != `ARF_CNT_MAX)) begin
			acc_cnt_r <= acc_cnt_r + `ARF_CNT_ONE;
		end
	end

endmodule : async_request_node_filter_high

// [bench/remote_node_model.sv]
// Model of remote bus nodes sending asynchronous requests
`timescale 1ns/100ps
module remote_node_model (
	// Clock
	input  wire logic          pclk,
	// Lookup toward the filter
	output logic               rx_valid,
	output arf_pkg::rx_req_s   rx_req
);
	import arf_pkg::*;
	initial begin
		rx_valid = 1'b0;
		rx_req   = '0;
	end
	task automatic send(input logic [9:0] b, input logic [5:0] n, input rx_ctx_e c);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_req   <= '{src: '{bus: b, node: n}, ctx: c};
		@(posedge pclk);
		rx_valid <= 1'b0;
		// Stale header scrambled so nothing leans on it after the pulse
		rx_req   <= ~rx_req;
	endtask : send
endmodule : remote_node_model

// [bench/arf_high_sva.sv]
// Checker for the upper-node request filter ports
`timescale 1ns/100ps
`include "arf_cfg.svh"
module arf_high_sva (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [31:0]        prdata,
	input  wire logic               pready,
	input  wire logic               pslverr,
	// Lookup
	input  wire logic [9:0]         own_bus_num,
	input  wire logic               rx_valid,
	input  wire arf_pkg::rx_req_s   rx_req,
	input  wire logic               verdict_valid,
	input  wire arf_pkg::verdict_s  verdict,
	input  wire logic [31:0]        filter_bits
);
	import arf_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic loc, req, fbit;
	assign loc  = rx_req.src.bus == own_bus_num || rx_req.src.bus == `ARF_LOCAL_ALIAS;
	assign req  = rx_valid && rx_req.ctx != CTX_OTHER;
	assign fbit = filter_bits[rx_req.src.node[4:0]];
	property p_lat; rx_valid |=> verdict_valid; endproperty
	a_lat: assert property (p_lat) else $error("verdict missing");
	property p_quiet; !rx_valid |=> !verdict_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("spurious verdict");
	property p_ack;
		verdict_valid |-> verdict.send_ack == verdict.accept && verdict.enqueue == verdict.accept;
	endproperty
	a_ack: assert property (p_ack) else $error("ack or queue differs");
	property p_far;
		req && !loc |=> verdict.accept == $past(filter_bits[31]) && verdict.nonlocal;
	endproperty
	a_far: assert property (p_far) else $error("nonlocal verdict wrong");
	property p_near;
		req && loc && rx_req.src.node[5] && rx_req.src.node != 6'h3f
		|=> verdict.accept == $past(fbit) && !verdict.nonlocal;
	endproperty
	a_near: assert property (p_near) else $error("local verdict wrong");
	property p_low; req && loc && !rx_req.src.node[5] |=> verdict.to_lower_filter && !verdict.accept; endproperty
	a_low: assert property (p_low) else $error("lower node judged");
	property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("apb wait wrong");
	property p_set;
		pready && pwrite && paddr == `ARF_SET_OFF |=> filter_bits == ($past(filter_bits) | $past(pwdata));
	endproperty
	a_set: assert property (p_set) else $error("set write wrong");
	property p_clr;
		pready && pwrite && paddr == `ARF_CLR_OFF |=> filter_bits == ($past(filter_bits) & ~$past(pwdata));
	endproperty
	a_clr: assert property (p_clr) else $error("clear write wrong");
	property p_rd;
		pready && !pwrite && (paddr == `ARF_SET_OFF || paddr == `ARF_CLR_OFF) |-> prdata == filter_bits && !pslverr;
	endproperty
	a_rd: assert property (p_rd) else $error("readback wrong");
	c_acc: cover property (verdict_valid && verdict.accept && !verdict.nonlocal);
	c_far: cover property (verdict_valid && verdict.accept && verdict.nonlocal);
	c_err: cover property (pready && pslverr);
endmodule : arf_high_sva

// [bench/testbench.sv]
// Testbench for the upper-node request filter
`timescale 1ns/100ps
`include "arf_cfg.svh"
module testbench;
	import arf_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        rx_valid, verdict_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, filter_bits, q;
	logic [9:0]  own_bus_num;
	rx_req_s     rx_req;
	verdict_s    verdict;
	int          failures, total_checks, cycles;
	async_request_node_filter_high dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .own_bus_num(own_bus_num), .rx_valid(rx_valid),
		.rx_req(rx_req), .verdict_valid(verdict_valid), .verdict(verdict),
		.filter_bits(filter_bits));
	remote_node_model src (.pclk(pclk), .rx_valid(rx_valid), .rx_req(rx_req));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// Bound so a stuck handshake cannot hang the run
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check("prdata", q, exp);
	endtask : rd
	task automatic look(input logic [9:0] b, input logic [5:0] n, input rx_ctx_e c, input logic acc);
		src.send(b, n, c);
		// Verdict was launched at the previous edge and stands through this one
		@(posedge pclk);
		check("verdict_valid", verdict_valid, 1'b1);
		check("accept", verdict.accept, acc);
		check("send_ack", verdict.send_ack, acc);
		check("enqueue", verdict.enqueue, acc);
	endtask : look
	initial begin
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 12'h000;
		pwdata      = 32'h0000_0000;
		own_bus_num = 10'h005;
		presetn     = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ARF_SET_OFF, 32'h0000_0000);
		rd(`ARF_CLR_OFF, 32'h0000_0000);
		look(10'h005, 6'h28, CTX_PHYS_REQ, 1'b0);
		look(10'h007, 6'h28, CTX_ASYNC_REQ_RX, 1'b0);
		$display("test reset done");
		apb(1'b1, `ARF_SET_OFF, 32'h8000_0019);
		apb(1'b1, `ARF_CLR_OFF, 32'h0000_0001);
		rd(`ARF_CLR_OFF, 32'h8000_0018);
		rd(`ARF_SET_OFF, 32'h8000_0018);
		$display("test set clear done");
		look(10'h005, 6'h24, CTX_PHYS_REQ, 1'b1);
		look(10'h005, 6'h25, CTX_ASYNC_REQ_RX, 1'b0);
		look(10'h005, 6'h23, CTX_ASYNC_REQ_RX, 1'b1);
		look(10'h005, 6'h20, CTX_PHYS_REQ, 1'b0);
		look(10'h3ff, 6'h24, CTX_ASYNC_REQ_RX, 1'b1);
		look(10'h007, 6'h28, CTX_PHYS_REQ, 1'b1);
		look(10'h005, 6'h04, CTX_PHYS_REQ, 1'b0);
		check("to_lower", verdict.to_lower_filter, 1'b1);
		apb(1'b1, `ARF_CLR_OFF, 32'h8000_0000);
		look(10'h007, 6'h24, CTX_PHYS_REQ, 1'b0);
		apb(1'b1, `ARF_SET_OFF, 32'h4000_0000);
		look(10'h005, 6'h3e, CTX_ASYNC_REQ_RX, 1'b1);
		own_bus_num <= 10'h007;
		look(10'h007, 6'h3e, CTX_PHYS_REQ, 1'b1);
		look(10'h005, 6'h3e, CTX_PHYS_REQ, 1'b0);
		look(10'h005, 6'h04, CTX_OTHER, 1'b1);
		check("nonlocal", verdict.nonlocal, 1'b1);
		check("filter_bits", filter_bits, 32'h4000_0018);
		$display("test lookup done");
		rd(`ARF_REJ_CNT_OFF, 32'h0000_0006);
		rd(`ARF_ACC_CNT_OFF, 32'h0000_0007);
		apb(1'b1, `ARF_REJ_CNT_OFF, 32'h0000_1234);
		rd(`ARF_REJ_CNT_OFF, 32'h0000_0000);
		rd(`ARF_ACC_CNT_OFF, 32'h0000_0007);
		$display("test counters done");
		apb(1'b0, 12'h200, 32'h0000_0000);
		check("pslverr", err, 1'b1);
		check("prdata", q, 32'h0000_0000);
		apb(1'b1, 12'h200, 32'hffff_ffff);
		check("pslverr", err, 1'b1);
		rd(`ARF_SET_OFF, 32'h4000_0018);
		$display("test unmapped done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ARF_CLR_OFF, 32'h0000_0000);
		rd(`ARF_ACC_CNT_OFF, 32'h0000_0000);
		look(10'h007, 6'h3e, CTX_PHYS_REQ, 1'b0);
		$display("test reset again done");
		summarize();
	end
endmodule : testbench
bind async_request_node_filter_high arf_high_sva chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .own_bus_num(own_bus_num),
	.rx_valid(rx_valid), .rx_req(rx_req), .verdict_valid(verdict_valid),
	.verdict(verdict), .filter_bits(filter_bits));
